// [dv/spi_far_end.sv]
// far-end model: slave for master tests, 200 ns master for slave tests
`timescale 1ns/1ps
module spi_far_end (
   input wire logic sck,
   input wire logic din,
   input wire spi_shifter_pkg::spi_cfg_t cfg,
   output logic dout,
   output logic m_sck,
   output logic ss_b
);
   logic [7:0] tx, sh, got;
   int k, n, edges;
   // phase 0 shows its first bit before any edge; phase 1 shows junk until its first edge
   assign dout = (k < 0) ? ~tx[0] :
                 tx[cfg.lsb_first_enable ? k : 7 - k];
   initial begin
      m_sck = 1'b0;
      ss_b = 1'b1;
   end
   // restart bit counters for a new byte
   task automatic arm(input logic [7:0] b);
      tx = b;
      n = 0;
      edges = 0;
      k = cfg.clock_phase ? -1 : 0;
   endtask
   // sample on one edge, change data on the other
   always @(sck) begin
      edges++;
      if ((sck != cfg.clock_polarity) ^ cfg.clock_phase) begin
         sh = cfg.lsb_first_enable ? {din, sh[7:1]} : {sh[6:0], din};
         n++;
         if (n == 8) begin
            got = sh;
            n = 0;
         end
      end else k = (k + 1) % 8;
   end
   // select low for the whole byte, high again after it; clock idles
   task automatic xfer(input logic [7:0] b);
      m_sck = cfg.clock_polarity;
      #200 arm(b);
      ss_b = 1'b0;
      #200 repeat (16) #100 m_sck = ~m_sck;
      #200 ss_b = 1'b1;
      #200;
   endtask
endmodule

// [dv/tb.sv]
// self-checking bench for the serial peripheral shifter
`timescale 1ns/1ps
`include "spi_shifter_defs.svh"
module tb;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   spi_shifter_pkg::spi_cfg_t cfg = 4'h0;
   logic data_write = 1'b0;
   logic data_read = 1'b0;
   logic [7:0] write_data = 8'h00;
   logic [7:0] rdata;
   logic txe, rxf, busy, sck_o, sck_oe, mo, mo_oe, so, so_oe;
   logic f_d, f_sck, f_ss_b, sck, mosi, miso;
   int n_mismatch = 0;
   int cmp_count = 0;
   int cyc = 0;
   int m;
   // four-state compare, so an unknown never matches
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin \
n_mismatch++; $display("unexpected %0t: got %h want %h", $time, a, e); end end
   always #12.5 clk = ~clk; // 40 MHz
   // each pin carries whoever enables it
   assign sck = sck_oe ? sck_o : f_sck;
   assign mosi = mo_oe ? mo : f_d;
   assign miso = so_oe ? so : f_d;
   serial_peripheral_shifter u_dut (.clk(clk), .rst_b(rst_b), .cfg(cfg),
      .half_period(`SPI_DIV_DEFAULT), .data_write(data_write),
      .write_data(write_data), .data_read(data_read),
      .serial_data_register(rdata), .tx_buffer_empty_flag(txe),
      .rx_buffer_full_flag(rxf), .busy(busy), .serial_clock_pin_in(sck),
      .serial_clock_pin_out(sck_o), .serial_clock_pin_oe(sck_oe),
      .mosi_in(mosi), .mosi_out(mo), .mosi_oe(mo_oe), .miso_in(miso),
      .miso_out(so), .miso_oe(so_oe), .slave_select_b(f_ss_b));
   // far end listens on the line the block drives in this role
   spi_far_end u_far (.sck(sck), .din(cfg.master_mode ? mosi : miso),
      .cfg(cfg), .dout(f_d), .m_sck(f_sck), .ss_b(f_ss_b));
   // inputs always move 2 ns after the rising edge
   task automatic step(input int c);
      repeat (c) @(posedge clk);
      #2;
   endtask
   task automatic wr(input logic [7:0] b);
      data_write = 1'b1;
      write_data = b;
      step(1);
      data_write = 1'b0;
   endtask
   task automatic rd;
      data_read = 1'b1;
      step(1);
      data_read = 1'b0;
   endtask
   task automatic wait_rx;
      for (int i = 0; i < 300 && rxf !== 1'b1; i++) step(1);
      `CHK(rxf, 1'b1)
   endtask
   task automatic close_out;
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // hang guard, far above the roughly 1100 cycles the run needs
   always @(posedge clk) begin
      cyc++;
      if (cyc > 20000) begin
         n_mismatch++;
         close_out();
      end
   end
   initial begin
      step(8);
      rst_b = 1'b1;
      step(3);
      `CHK({txe, rxf, rdata}, 10'h200)
      // master: every clock format, both bit orders
      for (m = 0; m < 8; m++) begin
         cfg = {1'b1, m[2:0]};
         step(2);
         u_far.arm(8'h6b ^ m[7:0]);
         `CHK(sck, cfg.clock_polarity)
         wr(8'h1d + m[7:0]);
         wait_rx();
         `CHK(u_far.got, 8'h1d + m[7:0])
         `CHK(rdata, 8'h6b ^ m[7:0])
         `CHK(u_far.edges, 16)
         rd();
         `CHK(rxf, 1'b0)
      end
      // queued byte, refused write, overrun kept silent
      cfg = 4'h8;
      step(2);
      u_far.arm(8'h5e);
      wr(8'h96);
      `CHK(txe, 1'b0)
      step(1);
      `CHK({txe, busy}, 2'h3)
      wr(8'h47);
      step(1);
      wr(8'hee);
      `CHK(txe, 1'b0)
      wait_rx();
      // a different far-end byte next, so a lost overrun is visible
      u_far.arm(8'ha1);
      step(1);
      `CHK({txe, busy}, 2'h3)
      step(80);
      `CHK({rxf, busy, rdata}, 10'h25e)
      `CHK(u_far.got, 8'h47)
      rd();
      // slave: the far end clocks at 200 ns
      for (m = 0; m < 4; m++) begin
         cfg = {1'b0, m[0], m[1], m[0]};
         step(2);
         wr(8'hc6 ^ m[7:0]);
         step(2);
         `CHK(so_oe, 1'b0)
         u_far.xfer(8'h39 + m[7:0]);
         step(4);
         wait_rx();
         `CHK(rdata, 8'h39 + m[7:0])
         `CHK(u_far.got, 8'hc6 ^ m[7:0])
         rd();
      end
      close_out();
   end
endmodule

// [hw/serial_peripheral_shifter.sv]
// byte-wide serial peripheral port, master or slave, double buffered
`timescale 1ns/1ps
`include "spi_shifter_defs.svh"
module serial_peripheral_shifter (
   input wire logic clk,
   input wire logic rst_b,
   input wire spi_shifter_pkg::spi_cfg_t cfg,
   input wire logic [`SPI_DIV_W-1:0] half_period,
   input wire logic data_write,
   input wire logic [7:0] write_data,
   input wire logic data_read,
   output logic [7:0] serial_data_register,
   output logic tx_buffer_empty_flag,
   output logic rx_buffer_full_flag,
   output logic busy,
   input wire logic serial_clock_pin_in,
   output logic serial_clock_pin_out,
   output logic serial_clock_pin_oe,
   input wire logic mosi_in,
   output logic mosi_out,
   output logic mosi_oe,
   input wire logic miso_in,
   output logic miso_out,
   output logic miso_oe,
   input wire logic slave_select_b
);
   logic rst_meta, rst_sync;
   logic sck_meta, sck_sync;
   logic ss_meta, ss_b;
   logic mosi_meta, mosi_s, miso_meta, miso_s;
   logic sck_prev;
   spi_shifter_pkg::spi_state_t state;
   logic [7:0] tx_buf, shifter;
   logic [4:0] edge_cnt;
   logic [`SPI_DIV_W-1:0] div_cnt;
   logic tick, sck_int, start, sck_edge;
   logic lead_edge, trail_edge, sample_edge, shift_edge, done;
   logic in_bit, out_bit;
   logic [7:0] rx_byte;
   logic [3:0] sample_cnt;

   // reset released through two flops
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync <= rst_meta;
      end
   end

   // pin synchronisers; first stage is read only by the second
   always_ff @(posedge clk or negedge rst_sync) begin
      if (!rst_sync) begin
         sck_meta <= 1'b0;
         sck_sync <= 1'b0;
         ss_meta <= 1'b1;
         ss_b <= 1'b1;
      end else begin
         sck_meta <= serial_clock_pin_in;
         sck_sync <= sck_meta;
         ss_meta <= slave_select_b;
         ss_b <= ss_meta;
      end
   end

   always_ff @(posedge clk or negedge rst_sync) begin
      if (!rst_sync) begin
         mosi_meta <= 1'b0;
         mosi_s <= 1'b0;
         miso_meta <= 1'b0;
         miso_s <= 1'b0;
         sck_prev <= 1'b0;
      end else begin
         mosi_meta <= mosi_in;
         mosi_s <= mosi_meta;
         miso_meta <= miso_in;
         miso_s <= miso_meta;
         sck_prev <= sck_sync;
      end
   end

   // bit picked from the shifter end that matches the bit order
   function automatic logic pick_bit(input logic [7:0] v, input logic lsb);
      pick_bit = lsb ? v[0] : v[7];
   endfunction

   // one sampled bit entering the shifter at the end opposite the sent bit
   function automatic logic [7:0] shift_in(input logic [7:0] v,
                                          input logic b,
                                          input logic lsb);
      shift_in = lsb ? {b, v[7:1]} : {v[6:0], b};
   endfunction

   // half-period tick for master clock generation; the input
   // synchroniser costs two clocks, so half_period below 2 samples stale
   always_ff @(posedge clk or negedge rst_sync) begin
      if (!rst_sync) begin
         div_cnt <= '0;
      end else if (state == spi_shifter_pkg::st_idle || tick) begin
         div_cnt <= '0;
      end else begin
         div_cnt <= div_cnt + 1'b1;
      end
   end
   assign tick = cfg.master_mode && state != spi_shifter_pkg::st_idle &&
                 div_cnt >= half_period;

   // edge source: own tick as master, pin edge as slave while selected
   assign sck_edge = cfg.master_mode ? tick :
                     (!ss_b && (sck_sync != sck_prev));
   // edges counted 1..16; odd edges lead, even edges trail
   assign lead_edge = sck_edge && !edge_cnt[0] &&
                      state == spi_shifter_pkg::st_shift;
   assign trail_edge = sck_edge && edge_cnt[0] &&
                       state == spi_shifter_pkg::st_shift;
   // phase 0 samples on leading edge, phase 1 on trailing edge
   assign sample_edge = cfg.clock_phase ? trail_edge : lead_edge;
   assign shift_edge = cfg.clock_phase ? lead_edge : trail_edge;
   assign done = trail_edge && edge_cnt == `SPI_LAST_EDGE - 5'h1;
   // sample the partner's line for our role
   assign in_bit = cfg.master_mode ? miso_s : mosi_s;
   // phase 1 takes its last sample on the closing edge itself, so the
   // byte handed over must already hold that bit
   assign rx_byte = cfg.clock_phase ?
                    shift_in(shifter, in_bit, cfg.lsb_first_enable) :
                    shifter;
   // master start needs a queued byte; slave start also needs select low
   assign start = !tx_buffer_empty_flag &&
                  (cfg.master_mode || !ss_b);

   // transfer sequencer
   always_ff @(posedge clk or negedge rst_sync) begin
      if (!rst_sync) begin
         state <= spi_shifter_pkg::st_idle;
         edge_cnt <= 5'h0;
      end else begin
         case (state)
            spi_shifter_pkg::st_idle: begin
               edge_cnt <= 5'h0;
               if (start) begin
                  state <= spi_shifter_pkg::st_shift;
               end
            end
            spi_shifter_pkg::st_shift: begin
               if (!cfg.master_mode && ss_b) begin
                  // select lost mid-byte: abandon the transfer
                  state <= spi_shifter_pkg::st_idle;
               end else if (done) begin
                  edge_cnt <= 5'h0;
                  // phase 0 slave waits for select to rise again
                  if (start && (cfg.master_mode || cfg.clock_phase)) begin
                     state <= spi_shifter_pkg::st_shift;
                  end else begin
                     state <= spi_shifter_pkg::st_lead;
                  end
               end else if (sck_edge) begin
                  edge_cnt <= edge_cnt + 5'h1;
               end
            end
            default: begin
               // slave phase 0 gap: needs select high then low
               if (cfg.master_mode || cfg.clock_phase || ss_b) begin
                  state <= spi_shifter_pkg::st_idle;
               end
            end
         endcase
      end
   end

   // shift register: load, sample into it, rotate out on shift edge
   always_ff @(posedge clk or negedge rst_sync) begin
      if (!rst_sync) begin
         shifter <= `SPI_DATA_RESET;
         out_bit <= 1'b0;
      end else if ((state == spi_shifter_pkg::st_idle ||
                   (done && cfg.master_mode) ||
                   (done && cfg.clock_phase)) && start) begin
         shifter <= tx_buf;
         out_bit <= pick_bit(tx_buf, cfg.lsb_first_enable);
      end else if (sample_edge) begin
         // bit enters at the end opposite the one being sent
         shifter <= shift_in(shifter, in_bit,
                             cfg.lsb_first_enable);
      end else if (shift_edge) begin
         // phase 1 edge one re-presents the loaded first bit
         out_bit <= pick_bit(shifter, cfg.lsb_first_enable);
      end
   end

   // transmit buffer: one byte queued while another shifts
   always_ff @(posedge clk or negedge rst_sync) begin
      if (!rst_sync) begin
         tx_buf <= `SPI_DATA_RESET;
         tx_buffer_empty_flag <= 1'b1;
      end else if (data_write && tx_buffer_empty_flag) begin
         tx_buf <= write_data;
         tx_buffer_empty_flag <= 1'b0;
      end else if (start && (state == spi_shifter_pkg::st_idle ||
                   (done && (cfg.master_mode || cfg.clock_phase)))) begin
         tx_buffer_empty_flag <= 1'b1;
      end
   end

   // receive buffer; an unread byte is kept and the new one dropped
   always_ff @(posedge clk or negedge rst_sync) begin
      if (!rst_sync) begin
         serial_data_register <= `SPI_DATA_RESET;
         rx_buffer_full_flag <= 1'b0;
      end else if (done && !rx_buffer_full_flag) begin
         serial_data_register <= rx_byte;
         rx_buffer_full_flag <= 1'b1;
      end else if (data_read) begin
         // a set in the same cycle wins, as the branch above comes first
         rx_buffer_full_flag <= 1'b0;
      end
   end

   // master clock level: idles at polarity, toggles each tick
   always_ff @(posedge clk or negedge rst_sync) begin
      if (!rst_sync) begin
         sck_int <= 1'b0;
      end else if (state != spi_shifter_pkg::st_shift) begin
         sck_int <= 1'b0;
      end else if (tick) begin
         sck_int <= ~sck_int;
      end
   end

   // pin drivers; polarity only inverts the clock
   assign serial_clock_pin_out = sck_int ^ cfg.clock_polarity;
   assign serial_clock_pin_oe = cfg.master_mode;
   assign mosi_out = out_bit;
   assign mosi_oe = cfg.master_mode;
   assign miso_out = out_bit;
   assign miso_oe = !cfg.master_mode && !ss_b;
   assign busy = state != spi_shifter_pkg::st_idle;

   // independent count of samples in the current byte, for checking
   always_ff @(posedge clk or negedge rst_sync) begin
      if (!rst_sync) begin
         sample_cnt <= 4'h0;
      end else if (state != spi_shifter_pkg::st_shift || done) begin
         sample_cnt <= 4'h0;
      end else if (sample_edge) begin
         sample_cnt <= sample_cnt + 4'h1;
      end
   end

   // a finished byte has taken eight samples; phase 1 takes its last at done
   property p_done_count;
      @(posedge clk) disable iff (!rst_sync)
      done |-> sample_cnt + {3'h0, cfg.clock_phase} == `SPI_BITS;
   endproperty
   a_done_count: assert property (p_done_count)
      else $error("transfer ended at wrong edge count");

   property p_rx_fill;
      @(posedge clk) disable iff (!rst_sync)
      (done && !rx_buffer_full_flag) |=> rx_buffer_full_flag &&
         serial_data_register == $past(rx_byte);
   endproperty
   a_rx_fill: assert property (p_rx_fill)
      else $error("receive buffer not filled at end");

   property p_overrun_keep;
      @(posedge clk) disable iff (!rst_sync)
      (done && rx_buffer_full_flag) |=> $stable(serial_data_register);
   endproperty
   a_overrun_keep: assert property (p_overrun_keep)
      else $error("overrun replaced unread byte");

   sequence s_start_idle;
      state == spi_shifter_pkg::st_idle && start;
   endsequence
   property p_load;
      @(posedge clk) disable iff (!rst_sync)
      s_start_idle |=> tx_buffer_empty_flag &&
         state == spi_shifter_pkg::st_shift;
   endproperty
   a_load: assert property (p_load)
      else $error("queued byte not moved to shifter");

   property p_write;
      @(posedge clk) disable iff (!rst_sync)
      (data_write && tx_buffer_empty_flag) |=> !tx_buffer_empty_flag;
   endproperty
   a_write: assert property (p_write)
      else $error("write did not fill transmit buffer");

   property p_chain;
      @(posedge clk) disable iff (!rst_sync)
      (done && cfg.master_mode && !tx_buffer_empty_flag) |=>
         state == spi_shifter_pkg::st_shift && edge_cnt == 5'h0;
   endproperty
   a_chain: assert property (p_chain)
      else $error("queued byte did not start at once");

   property p_idle_clock;
      @(posedge clk) disable iff (!rst_sync)
      (state != spi_shifter_pkg::st_shift) |->
         serial_clock_pin_out == cfg.clock_polarity;
   endproperty
   a_idle_clock: assert property (p_idle_clock)
      else $error("serial clock not at idle polarity");

   property p_first_bit;
      @(posedge clk) disable iff (!rst_sync)
      s_start_idle |=> out_bit == pick_bit($past(tx_buf),
                                           cfg.lsb_first_enable);
   endproperty
   a_first_bit: assert property (p_first_bit)
      else $error("first bit not presented before first edge");
endmodule

// [hw/spi_shifter_defs.svh]
// constants for the serial peripheral shifter
`ifndef SPI_SHIFTER_DEFS_SVH
`define SPI_SHIFTER_DEFS_SVH
`define SPI_BITS 4'h8
`define SPI_LAST_EDGE 5'h10
`define SPI_DIV_W 8
`define SPI_DIV_DEFAULT 8'h03
`define SPI_DATA_RESET 8'h00
`endif

// [hw/spi_shifter_pkg.sv]
// types shared by the serial peripheral shifter
package spi_shifter_pkg;
   typedef struct packed {
      logic master_mode;
      logic clock_polarity;
      logic clock_phase;
      logic lsb_first_enable;
   } spi_cfg_t;
   typedef enum logic [1:0] {st_idle, st_lead, st_shift} spi_state_t;
endpackage
